// file: hdl/iprio_defines.svh
// iprio_defines.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the interrupt priority design files
`ifndef IPRIO_DEFINES_SVH
`define IPRIO_DEFINES_SVH

// ----------------------------------------
// register word offsets (byte address = 4 * index)
// ----------------------------------------
`define IPRIO_IDX_LOW_G1     8'hb2
`define IPRIO_IDX_HIGH_G1    8'hb3
`define IPRIO_IDX_HIGH_G0    8'hb7
`define IPRIO_IDX_LOW_G0     8'hb8
`define IPRIO_IDX_ENABLE     8'hc0
`define IPRIO_IDX_STATUS     8'hc1
`define IPRIO_IDX_MASK       8'hc2
`define IPRIO_IDX_PENDING    8'hc3
`define IPRIO_IDX_GRANT      8'hc4

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define IPRIO_G0_BITS        7
`define IPRIO_G1_BITS        3
`define IPRIO_NSRC           10
`define IPRIO_RST_PRIO       8'h00
`define IPRIO_RST_ENABLE     10'h000
`define IPRIO_EVT_GRANT      0
`define IPRIO_EVT_OVERRUN    1
`define IPRIO_EVT_BITS       2

// ----------------------------------------
// timing: state time and poll window
// ----------------------------------------
`define IPRIO_STATE_NS       80
`define IPRIO_CLK_NS         40
`define IPRIO_STATE_CYC      ((`IPRIO_STATE_NS + `IPRIO_CLK_NS - 1) / `IPRIO_CLK_NS)
`define IPRIO_POLL_STATES    4

`endif

// file: hdl/iprio_pkg.sv
// iprio_pkg.sv: types for the interrupt priority block
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none
package iprio_pkg;
   typedef logic [1:0] iprio_level_t;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_REQUEST = 3'b010,
      ST_WAIT    = 3'b100
   } iprio_state_t;
endpackage : iprio_pkg
`default_nettype wire

// file: hdl/iprio_slot.sv
// iprio_slot.sv: one source slot: pin sync, latch, level forming
// assumes: clk_i single clock domain, rst_i synchronous active high
`timescale 1ns/100ps
`default_nettype none
module iprio_slot
(
   input  wire logic                 clk_i,        // core clock
   input  wire logic                 rst_i,        // sync reset
   input  wire logic                 req_i,        // raw request, any domain
   input  wire logic                 sample_i,     // this slot's sample state
   input  wire logic                 clear_i,      // request served
   input  wire logic                 prio_high_i,  // high-register bit
   input  wire logic                 prio_low_i,   // low-register bit
   output logic                      latched_o,    // latched request
   output iprio_pkg::iprio_level_t   level_o       // 0 lowest, 3 highest
);
   logic sync_a;
   logic sync_b;
   logic latched;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync_a  <= 1'b0;
         sync_b  <= 1'b0;
         latched <= 1'b0;
      end
      else
      begin
         sync_a <= req_i;
         sync_b <= sync_a;
         // set wins over clear: a fresh sample is never lost
         if (sample_i && sync_b)
            latched <= 1'b1;
         else if (clear_i)
            latched <= 1'b0;
      end
   end

   assign latched_o = latched;
   assign level_o   = {prio_high_i, prio_low_i};
endmodule // iprio_slot
`default_nettype wire

// file: hdl/iprio_ctrl.sv
// iprio_ctrl.sv: interrupt priority controller with classic Wishbone slave
// assumes: requests may come from pins, synchronised inside; core acks grants
//
// Summary of operation
// - each source level is {high bit, low bit}, 0 lowest and 3 highest.
// - group-0 low bits 6..0 serve counter array, timer2, serial, timer1, ext1, timer0, ext0.
// - group-1 bits 2..0 serve global suspend/resume, USB function, hub/start-of-frame.
// - reset clears every implemented priority bit, all sources at level 0.
// - a request goes through sample, poll, then context-switch request.
// - sources are sampled once per four-state window, two per state time, four (ids 0, 1, 8, 9) at phase 0.
// - one further state time after the poll issues the context-switch request.
`timescale 1ns/100ps
`default_nettype none
`include "iprio_defines.svh"
module iprio_ctrl
#(
   parameter int NSRC      = `IPRIO_NSRC,
   parameter int STATE_CYC = `IPRIO_STATE_CYC
)
(
   input  wire logic              clk_i,       // core clock, 25 MHz
   input  wire logic              rst_i,       // sync reset, active high
   input  wire logic [7:0]        adr_i,       // wishbone word address
   input  wire logic [31:0]       dat_i,       // wishbone write data
   output logic      [31:0]       dat_o,       // wishbone read data
   input  wire logic              we_i,        // write enable
   input  wire logic [3:0]        sel_i,       // byte selects
   input  wire logic              cyc_i,       // cycle
   input  wire logic              stb_i,       // strobe
   output logic                   ack_o,       // acknowledge
   output logic                   err_o,       // unmapped address
   input  wire logic [NSRC-1:0]   req_i,       // source requests, bit order as id
   output logic                   cs_req_o,    // context-switch request
   output logic [3:0]             cs_src_o,    // granted source id
   output iprio_pkg::iprio_level_t cs_level_o, // granted level
   input  wire logic              cs_ack_i,    // core took the request
   output logic                   irq_o        // event interrupt
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [6:0]      prio_low_g0;
   logic [6:0]      prio_high_g0;
   logic [2:0]      prio_low_g1;
   logic [2:0]      prio_high_g1;
   logic [NSRC-1:0] enable;
   logic [`IPRIO_EVT_BITS-1:0] status;
   logic [`IPRIO_EVT_BITS-1:0] mask;
   logic            ack;
   logic            err;
   logic [31:0]     rdata;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // answer cycle masks the request, so a held strobe is not taken twice
   wire req_new  = cyc_i && stb_i && !ack && !err;
   wire wr_lane0 = req_new && we_i && sel_i[0];
   wire hit_lg1  = adr_i == `IPRIO_IDX_LOW_G1;
   wire hit_hg1  = adr_i == `IPRIO_IDX_HIGH_G1;
   wire hit_hg0  = adr_i == `IPRIO_IDX_HIGH_G0;
   wire hit_lg0  = adr_i == `IPRIO_IDX_LOW_G0;
   wire hit_en   = adr_i == `IPRIO_IDX_ENABLE;
   wire hit_st   = adr_i == `IPRIO_IDX_STATUS;
   wire hit_mk   = adr_i == `IPRIO_IDX_MASK;
   wire hit_pd   = adr_i == `IPRIO_IDX_PENDING;
   wire hit_gr   = adr_i == `IPRIO_IDX_GRANT;
   wire mapped   = hit_lg1 | hit_hg1 | hit_hg0 | hit_lg0 | hit_en
                 | hit_st | hit_mk | hit_pd | hit_gr;
   wire wr_en_lo = req_new && we_i && sel_i[0] && hit_en;
   wire wr_en_hi = req_new && we_i && sel_i[1] && hit_en;

   // ----------------------------------------
   // state-time divider and poll phase
   // ----------------------------------------
   logic [7:0] div_cnt;
   logic [1:0] phase;
   // state time rounded up to whole clocks; phase wraps every four states
   wire state_tick = div_cnt == 8'(STATE_CYC - 1);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_cnt <= 8'h00;
         phase   <= 2'h0;
      end
      else if (state_tick)
      begin
         div_cnt <= 8'h00;
         phase   <= phase + 2'h1;
      end
      else
         div_cnt <= div_cnt + 8'h01;
   end

   // ----------------------------------------
   // source slots
   // ----------------------------------------
   // group 1 above group 0: ids 7..9 are hub/sof, function, suspend/resume
   wire [NSRC-1:0] prio_high = NSRC'({prio_high_g1, prio_high_g0});
   wire [NSRC-1:0] prio_low  = NSRC'({prio_low_g1, prio_low_g0});
   logic [NSRC-1:0] latched;
   logic [NSRC-1:0] served;
   iprio_pkg::iprio_level_t level [NSRC];

   genvar g;
   generate
      for (g = 0; g < NSRC; g++)
      begin : g_slot
         // two sources per state time, four (ids 0, 1, 8, 9) at phase 0; repeats every four states
         wire samp = state_tick && (phase == 2'((g / 2) % `IPRIO_POLL_STATES));
         iprio_slot u_slot
         (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .req_i       (req_i[g]),
            .sample_i    (samp),
            .clear_i     (served[g]),
            .prio_high_i (prio_high[g]),
            .prio_low_i  (prio_low[g]),
            .latched_o   (latched[g]),
            .level_o     (level[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // poll: highest level, lowest index on ties
   // ----------------------------------------
   // disabled sources stay latched and wait for their enable
   wire [NSRC-1:0] pending = latched & enable;
   logic [3:0] best_src;
   iprio_pkg::iprio_level_t best_lvl;
   logic best_any;

   always_comb
   begin
      best_src = 4'h0;
      best_lvl = 2'h0;
      best_any = 1'b0;
      // ascending scan, strict compare: the lowest id keeps a tie
      for (int i = 0; i < NSRC; i++)
         if (pending[i] && (!best_any || level[i] > best_lvl))
         begin
            best_src = 4'(i);
            best_lvl = level[i];
            best_any = 1'b1;
         end
   end

   // ----------------------------------------
   // sample, poll, then request one state later
   // ----------------------------------------
   iprio_pkg::iprio_state_t state;
   iprio_pkg::iprio_state_t next_state;
   logic [3:0] cs_src;
   iprio_pkg::iprio_level_t cs_level;
   // latch clears only on the core's ack, so a short pin pulse is still served
   wire grant_evt = (state == iprio_pkg::ST_REQUEST) && state_tick;
   wire overrun   = grant_evt && best_any && (best_lvl > cs_level);

   always_comb
   begin
      case (state)
         iprio_pkg::ST_IDLE:
            next_state = (state_tick && best_any) ? iprio_pkg::ST_REQUEST
                                                  : iprio_pkg::ST_IDLE;
         iprio_pkg::ST_REQUEST:
            next_state = state_tick ? iprio_pkg::ST_WAIT
                                    : iprio_pkg::ST_REQUEST;
         iprio_pkg::ST_WAIT:
            next_state = cs_ack_i ? iprio_pkg::ST_IDLE : iprio_pkg::ST_WAIT;
         default:
            next_state = iprio_pkg::ST_IDLE;
      endcase
   end

   always_comb
   begin
      served = '0;
      if (state == iprio_pkg::ST_WAIT && cs_ack_i)
         served[cs_src] = 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state    <= iprio_pkg::ST_IDLE;
         cs_src   <= 4'h0;
         cs_level <= 2'h0;
      end
      else
      begin
         state <= next_state;
         // poll result frozen at the poll edge
         if (state == iprio_pkg::ST_IDLE && state_tick && best_any)
         begin
            cs_src   <= best_src;
            cs_level <= best_lvl;
         end
      end
   end

   assign cs_req_o   = state == iprio_pkg::ST_WAIT;
   assign cs_src_o   = cs_src;
   assign cs_level_o = cs_level;

   // ----------------------------------------
   // register writes; reserved bits never stored
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prio_low_g0  <= 7'(`IPRIO_RST_PRIO);
         prio_high_g0 <= 7'(`IPRIO_RST_PRIO);
         prio_low_g1  <= 3'(`IPRIO_RST_PRIO);
         prio_high_g1 <= 3'(`IPRIO_RST_PRIO);
         enable       <= NSRC'(`IPRIO_RST_ENABLE);
         mask         <= '0;
      end
      else
      begin
         if (wr_lane0 && hit_lg0)
            prio_low_g0 <= dat_i[`IPRIO_G0_BITS-1:0];
         if (wr_lane0 && hit_hg0)
            prio_high_g0 <= dat_i[`IPRIO_G0_BITS-1:0];
         if (wr_lane0 && hit_lg1)
            prio_low_g1 <= dat_i[`IPRIO_G1_BITS-1:0];
         if (wr_lane0 && hit_hg1)
            prio_high_g1 <= dat_i[`IPRIO_G1_BITS-1:0];
         // enable bits 9:8 sit in lane 1
         if (wr_en_lo)
            enable[7:0] <= dat_i[7:0];
         if (wr_en_hi)
            enable[NSRC-1:8] <= dat_i[NSRC-1:8];
         if (wr_lane0 && hit_mk)
            mask <= dat_i[`IPRIO_EVT_BITS-1:0];
      end
   end

   // ----------------------------------------
   // event status and interrupt
   // ----------------------------------------
   // sticky events: set beats a write-one clear in the same cycle
   // bit 0 grant issued, bit 1 higher level seen while granting
   wire [`IPRIO_EVT_BITS-1:0] evt_set = {overrun, grant_evt};
   wire [`IPRIO_EVT_BITS-1:0] evt_clr = (wr_lane0 && hit_st)
                                        ? dat_i[`IPRIO_EVT_BITS-1:0] : '0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status <= '0;
      else
         status <= (status & ~evt_clr) | evt_set;
   end

   assign irq_o = |(status & mask);

   // ----------------------------------------
   // read mux and answer
   // ----------------------------------------
   // reserved bits read zero rather than anything left over
   wire [31:0] rd_mux =
        hit_lg0 ? {24'h0, 1'b0, prio_low_g0}
      : hit_hg0 ? {24'h0, 1'b0, prio_high_g0}
      : hit_lg1 ? {24'h0, 5'h00, prio_low_g1}
      : hit_hg1 ? {24'h0, 5'h00, prio_high_g1}
      : hit_en  ? {22'h0, enable}
      : hit_st  ? {30'h0, status}
      : hit_mk  ? {30'h0, mask}
      : hit_pd  ? {22'h0, latched}
      : hit_gr  ? {25'h0, cs_req_o, cs_level, cs_src}
      : 32'h0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack   <= 1'b0;
         err   <= 1'b0;
         rdata <= 32'h0;
      end
      else
      begin
         ack   <= req_new && mapped;
         err   <= req_new && !mapped;
         // data stays zero outside a read answer
         rdata <= (req_new && !we_i) ? rd_mux : 32'h0;
      end
   end

   assign ack_o = ack;
   assign err_o = err;
   assign dat_o = rdata;
endmodule // iprio_ctrl
`default_nettype wire

// file: dv/iprio_core_model.sv
// iprio_core_model.sv: processor core taking context-switch requests
// assumes: request held until acked; ack is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module iprio_core_model
(
   input  wire logic clk_i,    // core clock
   input  wire logic rst_i,    // sync reset
   input  wire logic cs_req_i, // pending switch
   input  wire logic slow_i,   // long service delay
   output logic      cs_ack_o  // request taken
);
   logic [3:0] cnt;
   // slow answer outlasts the pin sync, so a held pin cannot relatch
   always_ff @(posedge clk_i)
   begin
      cnt      <= (rst_i || !cs_req_i || cs_ack_o) ? 4'h0 : cnt + 4'h1;
      cs_ack_o <= !rst_i && cs_req_i && !cs_ack_o && cnt == (slow_i ? 4'hf : 4'h0);
   end
endmodule // iprio_core_model
`default_nettype wire

// file: dv/iprio_ctrl_sva.sv
// iprio_ctrl_sva.sv: port checker for the priority controller
// assumes: bound into iprio_ctrl, sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "iprio_defines.svh"
module iprio_ctrl_sva
#(
   parameter int NSRC      = 10,
   parameter int STATE_CYC = 2
)
(
   input  wire logic            clk_i,    // clock
   input  wire logic            rst_i,    // reset
   input  wire logic [7:0]      adr_i,    // index
   input  wire logic [31:0]     dat_i,    // wdata
   input  wire logic [31:0]     dat_o,    // rdata
   input  wire logic            we_i,     // write
   input  wire logic [3:0]      sel_i,    // lanes
   input  wire logic            cyc_i,    // cycle
   input  wire logic            stb_i,    // strobe
   input  wire logic            ack_o,    // ack
   input  wire logic            err_o,    // error
   input  wire logic [NSRC-1:0] req_i,    // sources
   input  wire logic            cs_req_o, // switch
   input  wire logic [3:0]      cs_src_o, // id
   input  wire iprio_pkg::iprio_level_t cs_level_o, // level
   input  wire logic            cs_ack_i, // core ack
   input  wire logic            irq_o     // irq
);
   wire mapped = adr_i inside {`IPRIO_IDX_LOW_G1, `IPRIO_IDX_HIGH_G1, `IPRIO_IDX_HIGH_G0,
      `IPRIO_IDX_LOW_G0, [`IPRIO_IDX_ENABLE:`IPRIO_IDX_GRANT]};
   wire g1_rd = !we_i && adr_i inside {`IPRIO_IDX_LOW_G1, `IPRIO_IDX_HIGH_G1};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o && !err_o;
   endsequence
   sequence s_wait;
      cs_req_o && !cs_ack_i;
   endsequence
   a_bus_answer: assert property (s_take |=> ack_o ^ err_o)
      else $error("bus request unanswered");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   a_unmapped_err: assert property (s_take ##0 !mapped |=> err_o)
      else $error("unmapped not refused");
   a_idle_data: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("data outside ack");
   a_rsvd_zero: assert property (ack_o && $past(g1_rd) |-> dat_o[31:3] == 29'h0)
      else $error("reserved bits nonzero");
   a_reset_quiet: assert property (disable iff (1'b0)
      rst_i |=> !cs_req_o && !ack_o && !irq_o) else $error("busy after reset");
   a_grant_hold: assert property (s_wait |=> cs_req_o && $stable({cs_src_o, cs_level_o}))
      else $error("grant moved while waiting");
   a_grant_drop: assert property (cs_req_o && cs_ack_i |=> !cs_req_o)
      else $error("grant kept after ack");
   a_src_range: assert property (cs_req_o |-> cs_src_o < 4'(NSRC))
      else $error("granted id out of range");
endmodule // iprio_ctrl_sva
bind iprio_ctrl iprio_ctrl_sva #(.NSRC(NSRC), .STATE_CYC(STATE_CYC)) sva_u
(
   .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
   .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .req_i(req_i),
   .cs_req_o(cs_req_o), .cs_src_o(cs_src_o), .cs_level_o(cs_level_o), .cs_ack_i(cs_ack_i),
   .irq_o(irq_o)
);
`default_nettype wire

// file: dv/iprio_ctrl_tb.sv
// iprio_ctrl_tb.sv: self-checking bench for the priority controller
// assumes: core model answers grants; checker bound from its own file
`timescale 1ns/100ps
`default_nettype none
`include "iprio_defines.svh"
module iprio_ctrl_tb;
   logic                    clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0;
   logic                    stb_i = 1'b0, slow = 1'b0, gseen = 1'b0, er;
   logic [3:0]              sel_i = 4'h0, cs_src_o;
   logic [7:0]              adr_i = 8'h00;
   logic [31:0]             dat_i = 32'h0, dat_o;
   logic [9:0]              req_i = 10'h000;
   logic                    ack_o, err_o, cs_req_o, cs_ack_i, irq_o;
   iprio_pkg::iprio_level_t cs_level_o;
   logic [7:0]              pr [4];
   logic [7:0]              pa [4] = '{`IPRIO_IDX_LOW_G1, `IPRIO_IDX_HIGH_G1,
                                       `IPRIO_IDX_HIGH_G0, `IPRIO_IDX_LOW_G0};
   logic [31:0]             rd_q [$];
   logic [5:0]              g_q [$];
   int                      n_fail = 0, compares = 0, n;
   always #20 clk_i = ~clk_i;
   iprio_ctrl dut_u
   (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
      .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o),
      .req_i(req_i), .cs_req_o(cs_req_o), .cs_src_o(cs_src_o), .cs_level_o(cs_level_o),
      .cs_ack_i(cs_ack_i), .irq_o(irq_o)
   );
   iprio_core_model core_u
   (
      .clk_i(clk_i), .rst_i(rst_i), .cs_req_i(cs_req_o), .slow_i(slow), .cs_ack_o(cs_ack_i)
   );
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // on a read, d is the value the monitor should see
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'hf, a, d};
      if (!w)
         rd_q.push_back(d);
      do @(posedge clk_i); while (!(ack_o || err_o));
      er = err_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask
   task automatic put_prio();
      for (int i = 0; i < 4; i++)
         wb(1'b1, pa[i], {24'h0, pr[i]});
      for (int i = 0; i < 4; i++)
         wb(1'b0, pa[i], {24'h0, pr[i]});
   endtask
   task automatic set_lvl(input int s, input logic [1:0] l);
      if (s < 7)
         {pr[2][s], pr[3][s]} = l;
      else
         {pr[1][s-7], pr[0][s-7]} = l;
   endtask
   always @(posedge clk_i)
   begin
      if (ack_o && !we_i)
         chk("read", dat_o, rd_q.size() ? rd_q.pop_front() : 32'hdeadbeef);
      if (cs_req_o && !gseen)
         chk("grant", {cs_src_o, cs_level_o}, g_q.size() ? g_q.pop_front() : 6'h3f);
      gseen <= cs_req_o;
   end
   initial
   begin
      #4000000;
      n_fail++;
      close_out();
   end
   initial
   begin
      void'($urandom(32598));
      pr = '{default: 8'h00};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++)
         wb(1'b0, pa[i], 32'h0);
      wb(1'b0, `IPRIO_IDX_ENABLE, 32'h0);
      wb(1'b1, 8'h40, 32'h1);
      chk("unmapped", er, 1'b1);
      for (int i = 0; i < 4; i++)
         pr[i] = 8'($urandom) & (i < 2 ? 8'h07 : 8'h7f);
      put_prio();
      $display("test reset_readback done");
      wb(1'b1, `IPRIO_IDX_MASK, 32'h1);
      // disabled while latching, so every source is pending at the first poll
      for (int s = 0; s < 10; s++)
      begin
         pr = '{default: 8'h00};
         set_lvl(s, 2'(s % 3 + 1));
         put_prio();
         wb(1'b1, `IPRIO_IDX_ENABLE, 32'h0);
         req_i <= 10'h3ff;
         repeat (10) @(posedge clk_i);
         req_i <= 10'h000;
         repeat (8) @(posedge clk_i);
         chk("refused", cs_req_o, 1'b0);
         g_q.push_back({4'(s), 2'(s % 3 + 1)});
         for (int j = 0; j < 10; j++)
            if (j != s)
               g_q.push_back({4'(j), 2'b00});
         slow <= 1'($urandom);
         wb(1'b1, `IPRIO_IDX_ENABLE, 32'h3ff);
         while (g_q.size() > 0 || cs_req_o)
            @(posedge clk_i);
      end
      chk("irq raised", irq_o, 1'b1);
      wb(1'b0, `IPRIO_IDX_STATUS, 32'h1);
      wb(1'b0, `IPRIO_IDX_MASK, 32'h1);
      wb(1'b1, `IPRIO_IDX_STATUS, 32'h3);
      @(posedge clk_i);
      chk("irq cleared", irq_o, 1'b0);
      wb(1'b0, `IPRIO_IDX_STATUS, 32'h0);
      $display("test priority_order done");
      wb(1'b1, `IPRIO_IDX_MASK, 32'h0);
      slow <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         int s;
         logic [1:0] l;
         s = $urandom % 10;
         l = 2'($urandom);
         set_lvl(s, l);
         put_prio();
         g_q.push_back({4'(s), l});
         req_i <= 10'h001 << s;
         for (n = 0; n < 40 && !cs_req_o; n++)
            @(posedge clk_i);
         chk("latency", 32'(n >= 4 && n <= 16), 32'h1);
         repeat (12) @(posedge clk_i);
         req_i <= 10'h000;
         while (cs_req_o)
            @(posedge clk_i);
         repeat (8) @(posedge clk_i);
      end
      chk("irq masked", irq_o, 1'b0);
      wb(1'b1, `IPRIO_IDX_MASK, 32'h1);
      @(posedge clk_i);
      chk("irq unmasked", irq_o, 1'b1);
      $display("test latency_mask done");
      // reset in mid-grant: every register, latch and grant must drop
      pr = '{8'h07, 8'h07, 8'h7f, 8'h7f};
      put_prio();
      g_q.push_back({4'h9, 2'h3});
      req_i <= 10'h200;
      for (n = 0; n < 40 && !cs_req_o; n++)
         @(posedge clk_i);
      wb(1'b0, `IPRIO_IDX_GRANT, {25'h0, 1'b1, 2'h3, 4'h9});
      wb(1'b0, `IPRIO_IDX_PENDING, 32'h200);
      {rst_i, req_i} <= {1'b1, 10'h000};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("reset quiet", {cs_req_o, irq_o}, 2'b00);
      for (int i = 0; i < 4; i++)
         wb(1'b0, pa[i], 32'h0);
      for (int i = 0; i < 4; i++)
         wb(1'b0, `IPRIO_IDX_ENABLE + 8'(i), 32'h0);
      $display("test midrun_reset done");
      close_out();
   end
endmodule // iprio_ctrl_tb
`default_nettype wire
